// *** logic/ohfu_regs.svh ***
// Constants for the operand helper function unit.
`ifndef OHFU_REGS_SVH
`define OHFU_REGS_SVH

`define OHFU_REG_WIDTH      6'h20
`define OHFU_CREG_WIDTH     3'h4
`define OHFU_FP_BIAS        10'h07F
`define OHFU_FP_EXP_SAT     10'h0FF
`define OHFU_FP_MAX_MAG     31'h7F7FFFFF
`define OHFU_FP_INT_EXP     10'h09E
`define OHFU_FP_FRAC_EXP    10'h096
`define OHFU_INT_MAX        32'h7FFFFFFF
`define OHFU_INT_MIN        32'h80000000
`define OHFU_DIV0_RESULT    32'h00000000
`define OHFU_RSP_RESET      32'h00000000

`endif

// *** logic/ohfu_pkg.sv ***
// Types shared by the operand helper function unit.
package ohfu_pkg;

  typedef enum logic [5:0] {
    OP_EQ, OP_NE, OP_LT, OP_GT, OP_LE, OP_GE,
    OP_AND, OP_OR, OP_XOR, OP_NOT, OP_INT,
    OP_CLZ, OP_UNARROW, OP_SNARROW, OP_BIT, OP_CREG, OP_REG,
    OP_INSERT, OP_GETU, OP_GETS, OP_SAT, OP_SATZ, OP_OVF, OP_FIELD,
    OP_FADD, OP_FSUB, OP_FMUL, OP_FEQ, OP_FGE, OP_FGT, OP_ITOF, OP_FTOI,
    OP_SDIV, OP_SREM, OP_UDIV, OP_UREM
  } ohfu_op_e;

  typedef struct packed {
    ohfu_op_e    op;
    logic [31:0] a;
    logic [31:0] b;
    logic [4:0]  lane;
    logic [4:0]  fld_pos;
    logic [5:0]  fld_len;
  } ohfu_req_s;

  typedef struct packed {
    logic [31:0] value;
    logic        flag;
  } ohfu_rsp_s;

endpackage

// *** logic/ohfu_lzc.sv ***
// Leading zero counter over a parameterised field.
`timescale 1ns/1ps

module ohfu_lzc #(
  parameter int W = 32
) (
  // Operand and count.
  input  wire logic [W-1:0]           value,
  output logic      [$clog2(W+1)-1:0] count
);
  localparam int CW = $clog2(W+1);

  always_comb begin
    count = CW'(W);
    for (int i = 0; i < W; i++) begin
      if (value[i]) begin
        count = CW'(W - 1 - i);
      end
    end
  end

endmodule // ohfu_lzc

// *** logic/ohfu_top.sv ***
// Operand helper function unit with one registered result stage.
`timescale 1ns/1ps
`include "ohfu_regs.svh"

// Summary of operation
// - Six signed compares give one flag, true when the relation holds.
// - AND, OR, XOR, NOT on boolean bit zero; XOR needs exactly one true.
// - Boolean to integer gives 0 for false, 1 for true.
// - Leading zeros of 32-bit operand; 0 if bit 31 set, 32 if zero.
// - Unsigned narrow keeps low n bits as an unsigned value.
// - Signed narrow reads low n bits as two's complement value.
// - Bit conversion yields operand bit zero; booleans first become 0/1.
// - Condition width conversion yields the operand's low four bits as they stand.
// - Register width conversion yields all 32 operand bits as they stand.
// - Lane insert zero-extends to n bits, shifts left lane times n.
// - Unsigned lane get shifts right lane times n, zero-extends n bits.
// - Signed lane get shifts right lane times n, sign-extends n bits.
// - Signed clamp to n-bit range, result sign-extended.
// - Clamp to n-bit signed range, result zero-extended.
// - Overflow flag true when operand lies outside n-bit signed range.
// - Single precision add, sub, mul, compares and integer conversions.
// - Signed and unsigned divide and remainder on two operands.
// - Field of m bits at b is arithmetic shift right, masked.

module ohfu_top #(
  parameter int N = 16
) (
  // Clock, reset and enable.
  input  wire logic              clock,
  input  wire logic              rst_n,
  input  wire logic              ce,
  // Request.
  input  wire logic              req_valid,
  input  wire ohfu_pkg::ohfu_req_s req,
  // Result.
  output logic                   rsp_valid_q,
  output ohfu_pkg::ohfu_rsp_s    rsp_q
);
  localparam logic [63:0] M64 = (64'h1 << N) - 64'h1;
  localparam logic [31:0] NMASK = M64[31:0];
  localparam logic signed [32:0] SMAX = (33'sh1 <<< (N - 1)) - 33'sh1;
  localparam logic signed [32:0] SMIN = -(33'sh1 <<< (N - 1));

  ohfu_pkg::ohfu_rsp_s rsp_d;
  logic [31:0] a;
  logic [31:0] b;
  logic        ba;
  logic        bb;
  logic [31:0] conv_src;
  logic [10:0] lane_sh;
  logic [31:0] lane_raw;
  logic signed [32:0] a_ext;
  logic        ovf;
  logic [31:0] clamp;
  logic [63:0] fmask;
  logic [5:0]  clz_cnt;

  assign a  = req.a;
  assign b  = req.b;
  assign ba = req.a[0];
  assign bb = req.b[0];

  function automatic logic [31:0] sext_n(input logic [31:0] x);
    return x[N-1] ? (x | ~NMASK) : (x & NMASK);
  endfunction

  // Boolean operands first become 0 or 1.
  assign conv_src = {31'h0, ba};

  // Lane offset is lane index times n.
  assign lane_sh  = 11'(req.lane) * 11'(N);
  assign lane_raw = 32'($signed(a) >>> lane_sh);

  // Range test against the n-bit signed limits.
  assign a_ext = $signed({a[31], a});
  assign ovf   = (a_ext > SMAX) || (a_ext < SMIN);
  assign clamp = (a_ext > SMAX) ? SMAX[31:0] :
                 (a_ext < SMIN) ? SMIN[31:0] : a;

  assign fmask = (64'h1 << req.fld_len) - 64'h1;

  ohfu_lzc #(.W(32)) u_clz (.value(a), .count(clz_cnt));

  // Float helpers: denormals flush to zero and results truncate, which
  // keeps the datapath to one cycle at the cost of strict rounding.
  function automatic logic [31:0] fp_pack(input logic z, input logic s,
                                          input logic signed [10:0] e,
                                          input logic [22:0] f);
    if (z || e <= 11'sh000) begin
      return 32'h00000000;
    end
    if (e >= $signed({1'b0, `OHFU_FP_EXP_SAT})) begin
      return {s, `OHFU_FP_MAX_MAG};
    end
    return {s, e[7:0], f};
  endfunction

  function automatic logic [23:0] fp_man(input logic [31:0] x);
    return (x[30:23] == 8'h00) ? 24'h000000 : {1'b1, x[22:0]};
  endfunction

  function automatic logic [31:0] fp_key(input logic [31:0] x);
    if (x[30:23] == 8'h00) begin
      return 32'h80000000;
    end
    return x[31] ? ~x : (x | 32'h80000000);
  endfunction

  logic [31:0] fx;
  logic [31:0] fy;
  logic [31:0] fl;
  logic [31:0] fs;
  logic [7:0]  fdiff;
  logic [23:0] fs_man;
  logic [24:0] fsum;
  logic [5:0]  fsum_lz;
  logic [31:0] fsum_pad;
  logic [31:0] fsum_nrm;
  logic [31:0] fadd_res;
  logic [47:0] fprod;
  logic [31:0] fmul_res;
  logic [31:0] itof_mag;
  logic [5:0]  itof_lz;
  logic [31:0] itof_nrm;
  logic [31:0] itof_res;
  logic [9:0]  ftoi_e;
  logic [31:0] ftoi_mag;
  logic [31:0] ftoi_res;
  logic [31:0] ka;
  logic [31:0] kb;

  // Add and subtract align the smaller magnitude.
  always_comb begin
    fx = a;
    fy = (req.op == ohfu_pkg::OP_FSUB) ? {~b[31], b[30:0]} : b;
    if ({fp_man(fx) != 24'h0, fx[30:0]} >= {fp_man(fy) != 24'h0, fy[30:0]})
    begin
      fl = fx;
      fs = fy;
    end else begin
      fl = fy;
      fs = fx;
    end
    fdiff  = fl[30:23] - fs[30:23];
    fs_man = (fdiff > 8'h18) ? 24'h0 : (fp_man(fs) >> fdiff);
    if (fl[31] == fs[31]) begin
      fsum = {1'b0, fp_man(fl)} + {1'b0, fs_man};
    end else begin
      fsum = {1'b0, fp_man(fl)} - {1'b0, fs_man};
    end
    fsum_pad = {fsum, 7'h00};
  end

  ohfu_lzc #(.W(32)) u_fadd_lz (.value(fsum_pad), .count(fsum_lz));

  always_comb begin
    fsum_nrm = fsum_pad << fsum_lz;
    fadd_res = fp_pack(fsum == 25'h0, fl[31],
                       $signed({3'h0, fl[30:23]}) + 11'sh001
                       - $signed({5'h00, fsum_lz}),
                       fsum_nrm[30:8]);
  end

  // Multiply keeps the top 24 product bits.
  always_comb begin
    fprod    = fp_man(a) * fp_man(b);
    fmul_res = fp_pack(fprod == 48'h0, a[31] ^ b[31],
                       $signed({3'h0, a[30:23]}) + $signed({3'h0, b[30:23]})
                       - $signed({1'b0, `OHFU_FP_BIAS})
                       + $signed({10'h000, fprod[47]}),
                       fprod[47] ? fprod[46:24] : fprod[45:23]);
  end

  assign itof_mag = a[31] ? (32'h0 - a) : a;

  ohfu_lzc #(.W(32)) u_itof_lz (.value(itof_mag), .count(itof_lz));

  always_comb begin
    itof_nrm = itof_mag << itof_lz;
    itof_res = fp_pack(a == 32'h0, a[31],
                       $signed({1'b0, `OHFU_FP_INT_EXP})
                       - $signed({5'h00, itof_lz}),
                       itof_nrm[30:8]);
    ftoi_e   = {2'h0, a[30:23]};
    ftoi_mag = 32'h0;
    if (fp_man(a) == 24'h0 || ftoi_e < `OHFU_FP_BIAS) begin
      ftoi_res = 32'h0;
    end else if (ftoi_e >= `OHFU_FP_INT_EXP) begin
      ftoi_res = a[31] ? `OHFU_INT_MIN : `OHFU_INT_MAX;
    end else begin
      if (ftoi_e >= `OHFU_FP_FRAC_EXP) begin
        ftoi_mag = {8'h00, fp_man(a)} << (ftoi_e - `OHFU_FP_FRAC_EXP);
      end else begin
        ftoi_mag = {8'h00, fp_man(a)} >> (`OHFU_FP_FRAC_EXP - ftoi_e);
      end
      ftoi_res = a[31] ? (32'h0 - ftoi_mag) : ftoi_mag;
    end
    ka = fp_key(a);
    kb = fp_key(b);
  end

  always_comb begin
    rsp_d = '0;
    case (req.op)
      ohfu_pkg::OP_EQ: rsp_d.flag = (a == b);
      ohfu_pkg::OP_NE: rsp_d.flag = (a != b);
      ohfu_pkg::OP_LT: rsp_d.flag = ($signed(a) < $signed(b));
      ohfu_pkg::OP_GT: rsp_d.flag = ($signed(a) > $signed(b));
      ohfu_pkg::OP_LE: rsp_d.flag = ($signed(a) <= $signed(b));
      ohfu_pkg::OP_GE: rsp_d.flag = ($signed(a) >= $signed(b));
      ohfu_pkg::OP_AND: rsp_d.flag = ba & bb;
      ohfu_pkg::OP_OR:  rsp_d.flag = ba | bb;
      ohfu_pkg::OP_XOR: rsp_d.flag = ba ^ bb;
      ohfu_pkg::OP_NOT: rsp_d.flag = ~ba;
      ohfu_pkg::OP_INT: rsp_d.value = conv_src;
      ohfu_pkg::OP_CLZ: rsp_d.value = {26'h0, clz_cnt};
      ohfu_pkg::OP_UNARROW: rsp_d.value = a & NMASK;
      ohfu_pkg::OP_SNARROW: begin
        rsp_d.value = sext_n(a);
        rsp_d.flag  = a[N-1];
      end
      ohfu_pkg::OP_BIT: rsp_d.value = {31'h0, a[0]};
      ohfu_pkg::OP_CREG: rsp_d.value = {28'h0, a[`OHFU_CREG_WIDTH-1:0]};
      ohfu_pkg::OP_REG: rsp_d.value = a;
      ohfu_pkg::OP_INSERT: rsp_d.value = 32'({32'h0, a & NMASK} << lane_sh);
      ohfu_pkg::OP_GETU: rsp_d.value = lane_raw & NMASK;
      ohfu_pkg::OP_GETS: rsp_d.value = sext_n(lane_raw);
      ohfu_pkg::OP_SAT: begin
        rsp_d.value = sext_n(clamp);
        rsp_d.flag  = ovf;
      end
      ohfu_pkg::OP_SATZ: begin
        rsp_d.value = clamp & NMASK;
        rsp_d.flag  = ovf;
      end
      ohfu_pkg::OP_OVF: rsp_d.flag = ovf;
      ohfu_pkg::OP_FIELD:
        rsp_d.value = 32'($signed(a) >>> req.fld_pos) & fmask[31:0];
      ohfu_pkg::OP_FADD: rsp_d.value = fadd_res;
      ohfu_pkg::OP_FSUB: rsp_d.value = fadd_res;
      ohfu_pkg::OP_FMUL: rsp_d.value = fmul_res;
      ohfu_pkg::OP_FEQ:  rsp_d.flag  = (ka == kb);
      ohfu_pkg::OP_FGE:  rsp_d.flag  = (ka >= kb);
      ohfu_pkg::OP_FGT:  rsp_d.flag  = (ka > kb);
      ohfu_pkg::OP_ITOF: rsp_d.value = itof_res;
      ohfu_pkg::OP_FTOI: rsp_d.value = ftoi_res;
      // Divide and remainder; a zero divisor returns a fixed value.
      ohfu_pkg::OP_SDIV: rsp_d.value = (b == 32'h0) ? `OHFU_DIV0_RESULT :
                                       32'($signed(a) / $signed(b));
      ohfu_pkg::OP_SREM: rsp_d.value = (b == 32'h0) ? `OHFU_DIV0_RESULT :
                                       32'($signed(a) % $signed(b));
      ohfu_pkg::OP_UDIV: rsp_d.value = (b == 32'h0) ? `OHFU_DIV0_RESULT :
                                       a / b;
      ohfu_pkg::OP_UREM: rsp_d.value = (b == 32'h0) ? `OHFU_DIV0_RESULT :
                                       a % b;
      default: rsp_d = '0;
    endcase
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      rsp_valid_q <= 1'b0;
    end else if (ce) begin
      rsp_valid_q <= req_valid;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      rsp_q <= '{value: `OHFU_RSP_RESET, flag: 1'b0};
    end else if (ce && req_valid) begin
      rsp_q <= rsp_d;
    end
  end

  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rst_n);

  sequence s_fire(ohfu_pkg::ohfu_op_e o);
    ce && req_valid && req.op == o;
  endsequence

  width_legal_a: assert property (N > 0 && N <= 32)
    else $error("width parameter out of range");
  cmp_less_a: assert property (s_fire(ohfu_pkg::OP_LT) |=>
    rsp_q.flag == ($signed($past(a)) < $signed($past(b))))
    else $error("less compare wrong");
  bool_xor_a: assert property (s_fire(ohfu_pkg::OP_XOR) |=>
    rsp_q.flag == ($past(ba) != $past(bb)))
    else $error("xor wrong");
  bool_int_a: assert property (s_fire(ohfu_pkg::OP_INT) |=>
    rsp_q.value == ($past(ba) ? 32'h00000001 : 32'h00000000))
    else $error("boolean conversion wrong");
  clz_zero_a: assert property (s_fire(ohfu_pkg::OP_CLZ)
    ##0 (a == 32'h0) |=> rsp_q.value == 32'h00000020)
    else $error("zero operand count not 32");
  clz_top_a: assert property (s_fire(ohfu_pkg::OP_CLZ)
    ##0 a[31] |=> rsp_q.value == 32'h00000000)
    else $error("top bit count not 0");
  creg_width_a: assert property (s_fire(ohfu_pkg::OP_CREG) |=>
    rsp_q.value == {28'h0, $past(a[3:0])})
    else $error("condition width wrong");
  ovf_edge_a: assert property (s_fire(ohfu_pkg::OP_OVF)
    ##0 (a_ext == SMAX + 33'sh1) |=> rsp_q.flag)
    else $error("overflow missed");
  sat_hold_a: assert property (s_fire(ohfu_pkg::OP_SAT) ##1
    !(ce && req_valid) |=> $stable(rsp_q) &&
    rsp_valid_q == ($past(ce) ? 1'b0 : $past(rsp_valid_q)))
    else $error("result not held");
  getu_range_a: assert property (s_fire(ohfu_pkg::OP_GETU) |=>
    (rsp_q.value & ~NMASK) == 32'h0)
    else $error("unsigned lane not narrowed");

endmodule // ohfu_top

// *** testbench/ohfu_issuer.sv ***
// Execution unit model that issues requests into the helper unit.
`timescale 1ns/1ps

module ohfu_issuer (
  // Request side.
  output logic                ce,
  output logic                req_valid,
  output ohfu_pkg::ohfu_req_s req
);
  initial begin
    ce        = 1'b1;
    req_valid = 1'b0;
    req       = '0;
  end

  // Idle operands are scrambled so a stale request never looks held.
  task automatic put(input ohfu_pkg::ohfu_req_s r, input logic v,
                     input logic c);
    ce        = c;
    req_valid = v;
    req       = v ? r : ~req;
  endtask
endmodule // ohfu_issuer

// *** testbench/tb_top.sv ***
// Self-checking bench for the operand helper function unit.
`timescale 1ns/1ps

`define CHK(nm, e, g) begin total_checks++; if ((g) !== (e)) begin \
  bad_count++; $display("wrong value %s exp %h got %h", nm, e, g); end end

module tb_top;
  localparam int N = 8;
  logic                clock = 1'b0;
  logic                rst_n = 1'b0;
  logic                ce;
  logic                req_valid;
  logic                rsp_valid_q;
  ohfu_pkg::ohfu_req_s req;
  ohfu_pkg::ohfu_req_s q;
  ohfu_pkg::ohfu_rsp_s rsp_q;
  int                  bad_count = 0;
  int                  total_checks = 0;
  logic                e_vld, e_flg, k_val, k_flg;
  logic [31:0]         e_val;
  logic [31:0]         xv;
  logic                xf, xkv, xkf;

  ohfu_top #(.N(N)) ohfu_top_inst (.clock(clock), .rst_n(rst_n), .ce(ce),
    .req_valid(req_valid), .req(req), .rsp_valid_q(rsp_valid_q),
    .rsp_q(rsp_q));
  ohfu_issuer ohfu_issuer_inst (.ce(ce), .req_valid(req_valid), .req(req));

  initial begin
    forever #4 clock = ~clock;
  end

  function automatic void mdl(input ohfu_pkg::ohfu_req_s q,
      output logic [31:0] v, output logic f, output logic kv,
      output logic kf);
    longint sa, sb, ua, ub, m, sg, t, r, c;
    int s;
    sa = longint'($signed(q.a));
    sb = longint'($signed(q.b));
    ua = longint'(q.a);
    ub = longint'(q.b);
    m = (64'sd1 <<< N) - 1;
    sg = 64'sd1 <<< (N - 1);
    s = int'(q.lane) * N;
    t = sa >>> s;
    c = sa < -sg ? -sg : (sa > sg - 1 ? sg - 1 : sa);
    r = 0;
    f = 1'b0;
    kv = 1'b0;
    kf = 1'b1;
    case (q.op)
      ohfu_pkg::OP_EQ: f = sa == sb;
      ohfu_pkg::OP_NE: f = sa != sb;
      ohfu_pkg::OP_LT: f = sa < sb;
      ohfu_pkg::OP_GT: f = sa > sb;
      ohfu_pkg::OP_LE: f = sa <= sb;
      ohfu_pkg::OP_GE: f = sa >= sb;
      ohfu_pkg::OP_AND: f = q.a[0] & q.b[0];
      ohfu_pkg::OP_OR: f = q.a[0] | q.b[0];
      ohfu_pkg::OP_XOR: f = q.a[0] ^ q.b[0];
      ohfu_pkg::OP_NOT: f = ~q.a[0];
      ohfu_pkg::OP_OVF: f = sa != c;
      default: begin
        kv = 1'b1;
        kf = 1'b0;
        case (q.op)
          ohfu_pkg::OP_INT, ohfu_pkg::OP_BIT: r = ua & 1;
          ohfu_pkg::OP_CLZ: begin
            r = 32;
            for (int i = 0; i < 32; i++) if (q.a[i]) r = 31 - i;
          end
          ohfu_pkg::OP_UNARROW: r = sa & m;
          ohfu_pkg::OP_SNARROW: begin
            r = ((sa & m) ^ sg) - sg;
            f = q.a[N-1];
            kf = 1'b1;
          end
          ohfu_pkg::OP_CREG: r = ua & 15;
          ohfu_pkg::OP_REG: r = ua;
          ohfu_pkg::OP_INSERT: r = (sa & m) << s;
          ohfu_pkg::OP_GETU: r = t & m;
          ohfu_pkg::OP_GETS: r = ((t & m) ^ sg) - sg;
          ohfu_pkg::OP_SAT, ohfu_pkg::OP_SATZ: begin
            r = (q.op == ohfu_pkg::OP_SAT) ? c : (c & m);
            f = sa != c;
            kf = 1'b1;
          end
          ohfu_pkg::OP_FIELD: r = (sa >>> q.fld_pos)
                                  & ((64'sd1 <<< q.fld_len) - 1);
          ohfu_pkg::OP_SDIV: r = sb == 0 ? 0 : sa / sb;
          ohfu_pkg::OP_SREM: r = sb == 0 ? 0 : sa % sb;
          ohfu_pkg::OP_UDIV: r = ub == 0 ? 0 : ua / ub;
          ohfu_pkg::OP_UREM: r = ub == 0 ? 0 : ua % ub;
          default: kf = 1'b1;
        endcase
      end
    endcase
    v = r[31:0];
  endfunction

  // Checks the previous cycle's outcome, then drives the next request.
  task automatic step(input logic v, input logic c, input logic [31:0] ev,
      input logic ef, input logic kv, input logic kf);
    @(negedge clock);
    `CHK("valid", e_vld, rsp_valid_q)
    if (k_flg) `CHK("flag", e_flg, rsp_q.flag)
    if (k_val) `CHK("value", e_val, rsp_q.value)
    ohfu_issuer_inst.put(q, v, c);
    if (c) begin
      e_vld = v;
      if (v) begin
        {e_val, e_flg, k_val, k_flg} = {ev, ef, kv, kf};
      end
    end
  endtask

  task automatic fv(input logic [5:0] o, input logic [31:0] a,
      input logic [31:0] b, input logic [31:0] ev, input logic ef,
      input logic fl);
    q = '0;
    q.op = ohfu_pkg::ohfu_op_e'(o);
    q.a = a;
    q.b = b;
    step(1'b1, 1'b1, ev, ef, ~fl, fl);
  endtask

  function automatic logic [31:0] pick();
    case ($urandom_range(0, 6))
      0: return 32'h00000000;
      1: return 32'h80000000;
      2: return 32'h7FFFFFFF;
      3: return 32'((1 << (N - 1)) - $urandom_range(0, 1));
      4: return -32'((1 << (N - 1)) + $urandom_range(0, 1));
      5: return $urandom() >> $urandom_range(0, 31);
      default: return $urandom();
    endcase
  endfunction

  task automatic end_sim();
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  initial begin
    repeat (100000) @(posedge clock);
    bad_count++;
    end_sim();
  end

  initial begin
    void'($urandom(32'hAD136C06));
    {e_vld, e_val, e_flg, k_val, k_flg} = {1'b0, 32'h00000000, 3'h3};
    q = '0;
    repeat (4) @(posedge clock);
    `CHK("reset rsp", 33'h000000000, rsp_q)
    @(negedge clock);
    rst_n = 1'b1;
    fv(6'h0B, 32'h00000000, 32'h00000000, 32'h00000020, 1'b0, 1'b0);
    for (int o = 0; o < 64; o++) begin
      if (o < 24 || o > 31) begin
        for (int i = 0; i < 40; i++) begin
          q.op = ohfu_pkg::ohfu_op_e'(o[5:0]);
          q.a = pick();
          q.b = (i % 3 == 0) ? 32'(i % 2) - 1 : pick();
          q.lane = 5'($urandom_range(0, 31));
          q.fld_pos = 5'($urandom_range(0, 31));
          q.fld_len = 6'($urandom_range(0, 63));
          mdl(q, xv, xf, xkv, xkf);
          step($urandom_range(0, 3) != 0, $urandom_range(0, 7) != 0,
               xv, xf, xkv, xkf);
        end
      end
    end
    fv(6'h18, 32'h3F800000, 32'h3F800000, 32'h40000000, 1'b0, 1'b0);
    fv(6'h19, 32'h3F800000, 32'h40400000, 32'hC0000000, 1'b0, 1'b0);
    fv(6'h1A, 32'h40000000, 32'h40400000, 32'h40C00000, 1'b0, 1'b0);
    fv(6'h1A, 32'h7F000000, 32'h40000000, 32'h7F7FFFFF, 1'b0, 1'b0);
    fv(6'h1B, 32'h00000000, 32'h80000000, 32'h00000000, 1'b1, 1'b1);
    fv(6'h1C, 32'h40000000, 32'h40400000, 32'h00000000, 1'b0, 1'b1);
    fv(6'h1D, 32'h40400000, 32'h40000000, 32'h00000000, 1'b1, 1'b1);
    fv(6'h1E, 32'hFFFFFFFE, 32'h00000000, 32'hC0000000, 1'b0, 1'b0);
    fv(6'h1F, 32'h40C00000, 32'h00000000, 32'h00000006, 1'b0, 1'b0);
    fv(6'h1F, 32'h4F800000, 32'h00000000, 32'h7FFFFFFF, 1'b0, 1'b0);
    step(1'b0, 1'b1, 32'h00000000, 1'b0, 1'b0, 1'b0);
    // A reset in mid-run must clear the result at once.
    @(negedge clock);
    rst_n = 1'b0;
    #1;
    `CHK("mid reset", 34'h000000000, {rsp_valid_q, rsp_q})
    {e_vld, e_val, e_flg} = '0;
    @(negedge clock);
    rst_n = 1'b1;
    fv(6'h0B, 32'h80000000, 32'h00000000, 32'h00000000, 1'b0, 1'b0);
    step(1'b0, 1'b1, 32'h00000000, 1'b0, 1'b0, 1'b0);
    step(1'b0, 1'b1, 32'h00000000, 1'b0, 1'b0, 1'b0);
    end_sim();
  end
endmodule // tb_top
